// ===== include/crtt_pkg.sv
package crtt_pkg;

  // buffer geometry and field widths
  localparam int NUM_BUF   = 15;
  localparam int BASIC_BUF = 14;
  localparam int ID_W      = 29;
  localparam int STAMP_W   = 16;
  localparam int STATE_W   = 4;

  // buffer state field encodings
  localparam logic [3:0] ST_RX_DISABLED = 4'h0;
  localparam logic [3:0] ST_RX_ARMED    = 4'h2;
  localparam logic [3:0] ST_RX_FULL     = 4'h4;
  localparam logic [3:0] ST_RX_OVERRUN  = 4'h6;
  localparam logic [3:0] ST_TX_IDLE     = 4'h8;
  localparam logic [3:0] ST_TX_SINGLE   = 4'hc;

  // global register byte offsets
  localparam logic [11:0] OFF_CONFIG     = 12'h000;
  localparam logic [11:0] OFF_GLOB_MASK  = 12'h004;
  localparam logic [11:0] OFF_BASIC_MASK = 12'h008;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h00c;
  localparam logic [11:0] OFF_IRQ_MASK   = 12'h010;
  localparam logic [11:0] OFF_STAMP_NOW  = 12'h014;
  localparam logic [11:0] OFF_TAGS       = 12'h018;

  // buffer region: addr[11:8] selects region, [7:4] buffer, [3:2] word
  localparam logic [3:0] BUF_REGION   = 4'h1;
  localparam logic [1:0] WORD_CONTROL = 2'h0;
  localparam logic [1:0] WORD_IDENT   = 2'h1;
  localparam logic [1:0] WORD_DATA    = 2'h2;
  localparam logic [1:0] WORD_STAMP   = 2'h3;

  // field positions
  localparam int CFG_BASIC_BIT = 0;
  localparam int CFG_LOCK_BIT  = 1;
  localparam int IDE_BIT       = 31;

  // values after reset
  localparam logic [3:0]  RST_STATE = ST_RX_DISABLED;
  localparam logic [31:0] RST_MASK  = 32'h0000_0000;
  localparam logic [15:0] RST_STAMP = 16'h0000;

  // mask word: base[15:5] id[28:18], base[2:0] id[17:15], ext[15:1] id[14:0]; 1 = don't care
  function automatic logic [ID_W-1:0] maskOf(input logic [31:0] w);
    maskOf = {w[15:5], w[2:0], w[31:17]};
  endfunction

endpackage

// ===== rtl/crtt_stamp_counter.sv
`timescale 1ns/1ps
`default_nettype none
module crtt_stamp_counter
(
  input  wire logic                         clk,
  input  wire logic                         rst,
  output logic [crtt_pkg::STAMP_W-1:0]      count
);

  typedef struct packed {
    logic [crtt_pkg::STAMP_W-1:0] cnt;
  } crtt_cnt_t;

  crtt_cnt_t st_reg;
  crtt_cnt_t st_next;

  // free-running time stamp, wraps silently
  always_comb
  begin
    st_next     = st_reg;
    st_next.cnt = st_reg.cnt + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st_reg.cnt <= crtt_pkg::RST_STAMP;
    else
      st_reg <= st_next;
  end

  assign count = st_reg.cnt;

endmodule
`default_nettype wire

// ===== rtl/crtt_id_match.sv
`timescale 1ns/1ps
`default_nettype none
module crtt_id_match
(
  input  wire logic [crtt_pkg::ID_W-1:0]                         hidId,
  input  wire logic                                              hidIde,
  input  wire logic [crtt_pkg::NUM_BUF-1:0][crtt_pkg::ID_W-1:0]  bufId,
  input  wire logic [crtt_pkg::NUM_BUF-1:0]                      bufIde,
  input  wire logic [31:0]                                       globMask,
  input  wire logic [31:0]                                       basicMask,
  input  wire logic                                              basicEn,
  output logic      [crtt_pkg::NUM_BUF-1:0]                      match
);

  logic [crtt_pkg::ID_W-1:0] gCare;
  logic [crtt_pkg::ID_W-1:0] bCare;

  // mask bits set to one are don't care
  assign gCare = ~crtt_pkg::maskOf(globMask);
  assign bCare = ~crtt_pkg::maskOf(basicMask);

  // per-buffer compare; the last buffer may use the basic masks instead
  for (genvar b = 0; b < crtt_pkg::NUM_BUF; b++)
  begin : g_cmp
    logic [crtt_pkg::ID_W-1:0] care;
    if (b == crtt_pkg::BASIC_BUF)
    begin : g_basic
      assign care = basicEn ? bCare : gCare;
    end
    else
    begin : g_glob
      assign care = gCare;
    end
    assign match[b] = (bufIde[b] == hidIde) && (((bufId[b] ^ hidId) & care) == '0);
  end

endmodule
`default_nettype wire

// ===== rtl/crtt_can_buffers.sv
// Contract
// - a cpu write of a reception-disabling value to a buffer state field clears its receive tag.
// - a buffer in the disabled state never takes an incoming frame.
// - a disabled and re-armed buffer stays armed when its own node sends a matching frame; here only if that frame's identifier was the last one scanned.
// - a buffer in the single-send state makes the device send its frame.
// - buffer 14 can be a basic path filtered by the basic masks.
// - a successful send stores the stamp sampled at its ack slot into the sending buffer.
// - a received frame stores the stamp sampled at its ack slot into the receiving buffer.
// - a correct frame is copied into the lowest numbered tagged buffer, skipping full ones while lockEn is set.
// - own frames are scanned too, and a scan of an unchanged identifier keeps the tags.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module crtt_can_buffers
(
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic [11:0]                   paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          hidValid,
  input  wire logic [crtt_pkg::ID_W-1:0]     hidId,
  input  wire logic                          hidIde,
  input  wire logic [31:0]                   hidData,
  input  wire logic                          hidOwn,
  input  wire logic                          ackSlot,
  input  wire logic                          frameOk,
  output logic                               txReq,
  output logic      [crtt_pkg::ID_W-1:0]     txId,
  output logic                               txIde,
  output logic      [31:0]                   txData,
  output logic                               irq
);

  localparam int NB = crtt_pkg::NUM_BUF;

  typedef struct packed {
    logic [NB-1:0][3:0]                  bufState;
    logic [NB-1:0][crtt_pkg::ID_W-1:0]   bufId;
    logic [NB-1:0]                       bufIde;
    logic [NB-1:0][31:0]                 bufData;
    logic [NB-1:0][crtt_pkg::STAMP_W-1:0] bufStamp;
    logic [NB-1:0]                       tag;
    logic [crtt_pkg::ID_W-1:0]           lastId;
    logic                                lastIde;
    logic                                lastValid;
    logic [31:0]                         globMask;
    logic [31:0]                         basicMask;
    logic                                basicEn;
    logic                                lockEn;
    logic [NB-1:0]                       irqStatus;
    logic [NB-1:0]                       irqMask;
    logic [crtt_pkg::STAMP_W-1:0]        ackStamp;
    logic [3:0]                          txBuf;
    logic                                txBusy;
    logic                                txReq;
    logic [crtt_pkg::ID_W-1:0]           txId;
    logic                                txIde;
    logic [31:0]                         txData;
    logic [31:0]                         prdata;
    logic                                pready;
    logic                                pslverr;
    logic                                irq;
  } crtt_core_t;

  crtt_core_t st_reg;
  crtt_core_t st_next;

  logic [crtt_pkg::STAMP_W-1:0] stampNow;
  logic [NB-1:0]                match;
  logic [NB-1:0]                elig;
  logic [NB-1:0]                txPend;
  logic [3:0]                   storeIdx;
  logic                         storeEn;
  logic                         ownDone;
  logic                         apbWrite;
  logic                         addrOk;
  logic                         inBufRegion;
  logic [3:0]                   selBuf;
  logic [1:0]                   selWord;
  logic                         wrCtrl;
  logic [31:0]                  rd;

  // lowest set bit of a buffer vector
  function automatic logic [3:0] lowestIdx(input logic [NB-1:0] v);
    lowestIdx = 4'h0;
    for (int i = NB - 1; i >= 0; i--)
    begin
      if (v[i])
        lowestIdx = 4'(i);
    end
  endfunction

  // states in which a buffer may take a frame
  function automatic logic rxCapable(input logic [3:0] s);
    rxCapable = (s == crtt_pkg::ST_RX_ARMED) || (s == crtt_pkg::ST_RX_FULL) ||
                (s == crtt_pkg::ST_RX_OVERRUN);
  endfunction

  crtt_stamp_counter u_stamp
  (
    .clk   (clk),
    .rst   (rst),
    .count (stampNow)
  );

  // identifier filters, buffer 14 optionally on the basic masks
  crtt_id_match u_match
  (
    .hidId     (hidId),
    .hidIde    (hidIde),
    .bufId     (st_reg.bufId),
    .bufIde    (st_reg.bufIde),
    .globMask  (st_reg.globMask),
    .basicMask (st_reg.basicMask),
    .basicEn   (st_reg.basicEn),
    .match     (match)
  );

  // apb decode
  assign inBufRegion = (paddr[11:8] == crtt_pkg::BUF_REGION) && (paddr[7:4] < 4'(NB));
  assign selBuf      = paddr[7:4];
  assign selWord     = paddr[3:2];
  assign apbWrite    = psel && penable && pwrite && st_reg.pready && addrOk;
  assign wrCtrl      = apbWrite && inBufRegion && (selWord == crtt_pkg::WORD_CONTROL);

  always_comb
  begin
    addrOk = inBufRegion;
    rd     = 32'h0000_0000;
    if (inBufRegion)
    begin
      unique case (selWord)
        crtt_pkg::WORD_CONTROL: rd = {28'h0000000, st_reg.bufState[selBuf]};
        crtt_pkg::WORD_IDENT:   rd = {st_reg.bufIde[selBuf], 2'h0, st_reg.bufId[selBuf]};
        crtt_pkg::WORD_DATA:    rd = st_reg.bufData[selBuf];
        crtt_pkg::WORD_STAMP:   rd = {16'h0000, st_reg.bufStamp[selBuf]};
      endcase
    end
    else
    begin
      addrOk = 1'b1;
      unique case (paddr)
        crtt_pkg::OFF_CONFIG:     rd = {30'h00000000, st_reg.lockEn, st_reg.basicEn};
        crtt_pkg::OFF_GLOB_MASK:  rd = st_reg.globMask;
        crtt_pkg::OFF_BASIC_MASK: rd = st_reg.basicMask;
        crtt_pkg::OFF_IRQ_STATUS: rd = {17'h00000, st_reg.irqStatus};
        crtt_pkg::OFF_IRQ_MASK:   rd = {17'h00000, st_reg.irqMask};
        crtt_pkg::OFF_STAMP_NOW:  rd = {16'h0000, stampNow};
        crtt_pkg::OFF_TAGS:       rd = {17'h00000, st_reg.tag};
        default:                  addrOk = 1'b0;
      endcase
    end
  end

  // target of a correct frame: tagged, able to receive, not locked when full
  always_comb
  begin
    for (int i = 0; i < NB; i++)
    begin
      elig[i] = st_reg.tag[i] && rxCapable(st_reg.bufState[i]) &&
                !(st_reg.lockEn && (st_reg.bufState[i] != crtt_pkg::ST_RX_ARMED));
      txPend[i] = (st_reg.bufState[i] == crtt_pkg::ST_TX_SINGLE);
    end
  end

  assign storeEn  = frameOk && (elig != '0);
  assign storeIdx = lowestIdx(elig);
  assign ownDone  = frameOk && hidOwn && st_reg.txBusy;

  // next state: scan, cpu access, frame completion, transmit launch
  always_comb
  begin
    st_next = st_reg;

    // scan of the hidden buffer; equal identifier keeps the old tags
    if (hidValid)
    begin
      if (!st_reg.lastValid || (hidId != st_reg.lastId) || (hidIde != st_reg.lastIde))
      begin
        for (int i = 0; i < NB; i++)
          st_next.tag[i] = match[i] && rxCapable(st_reg.bufState[i]);
      end
      st_next.lastId    = hidId;
      st_next.lastIde   = hidIde;
      st_next.lastValid = 1'b1;
    end

    // ack slot samples the stamp for both directions
    if (ackSlot)
      st_next.ackStamp = stampNow;

    // apb answer one cycle after setup
    st_next.pready  = psel && !penable;
    st_next.pslverr = psel && !penable && !addrOk;
    if (psel && !penable)
      st_next.prdata = rd;

    // register writes
    if (apbWrite)
    begin
      if (inBufRegion)
      begin
        unique case (selWord)
          crtt_pkg::WORD_CONTROL:
          begin
            st_next.bufState[selBuf] = pwdata[3:0];
            if (!rxCapable(pwdata[3:0]))
              st_next.tag[selBuf] = 1'b0;
          end
          crtt_pkg::WORD_IDENT:
          begin
            st_next.bufId[selBuf]  = pwdata[crtt_pkg::ID_W-1:0];
            st_next.bufIde[selBuf] = pwdata[crtt_pkg::IDE_BIT];
            st_next.tag[selBuf]    = 1'b0;
          end
          crtt_pkg::WORD_DATA:  st_next.bufData[selBuf] = pwdata;
          crtt_pkg::WORD_STAMP: st_next.bufData[selBuf] = st_reg.bufData[selBuf];
        endcase
      end
      else
      begin
        unique case (paddr)
          crtt_pkg::OFF_CONFIG:
          begin
            st_next.basicEn = pwdata[crtt_pkg::CFG_BASIC_BIT];
            st_next.lockEn  = pwdata[crtt_pkg::CFG_LOCK_BIT];
          end
          crtt_pkg::OFF_GLOB_MASK:  st_next.globMask  = pwdata;
          crtt_pkg::OFF_BASIC_MASK: st_next.basicMask = pwdata;
          crtt_pkg::OFF_IRQ_STATUS: st_next.irqStatus = st_reg.irqStatus & ~pwdata[NB-1:0];
          crtt_pkg::OFF_IRQ_MASK:   st_next.irqMask   = pwdata[NB-1:0];
          default:                  st_next.irqMask   = st_next.irqMask;
        endcase
      end
    end

    // correct frame goes to the lowest eligible tagged buffer
    if (storeEn)
    begin
      st_next.bufData[storeIdx]  = hidData;
      st_next.bufStamp[storeIdx] = st_reg.ackStamp;
      st_next.bufState[storeIdx] = (st_reg.bufState[storeIdx] == crtt_pkg::ST_RX_ARMED) ?
                                   crtt_pkg::ST_RX_FULL : crtt_pkg::ST_RX_OVERRUN;
      st_next.irqStatus[storeIdx] = 1'b1;
    end

    // own frame acknowledged: stamp the sender and end the single send
    if (ownDone)
    begin
      st_next.bufStamp[st_reg.txBuf]  = st_reg.ackStamp;
      st_next.bufState[st_reg.txBuf]  = crtt_pkg::ST_TX_IDLE;
      st_next.irqStatus[st_reg.txBuf] = 1'b1;
      st_next.txBusy = 1'b0;
      st_next.txReq  = 1'b0;
    end
    else if (!st_reg.txBusy && (txPend != '0))
    begin
      // launch the lowest buffer waiting in the single-send state
      st_next.txBusy = 1'b1;
      st_next.txReq  = 1'b1;
      st_next.txBuf  = lowestIdx(txPend);
      st_next.txId   = st_reg.bufId[lowestIdx(txPend)];
      st_next.txIde  = st_reg.bufIde[lowestIdx(txPend)];
      st_next.txData = st_reg.bufData[lowestIdx(txPend)];
    end

    st_next.irq = (st_next.irqStatus & st_next.irqMask) != '0;
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_reg           <= '0;
      st_reg.bufState  <= {NB{crtt_pkg::RST_STATE}};
      st_reg.globMask  <= crtt_pkg::RST_MASK;
      st_reg.basicMask <= crtt_pkg::RST_MASK;
      st_reg.ackStamp  <= crtt_pkg::RST_STAMP;
    end
    else
      st_reg <= st_next;
  end

  // outputs straight from the state register
  assign prdata  = st_reg.prdata;
  assign pready  = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign txReq   = st_reg.txReq;
  assign txId    = st_reg.txId;
  assign txIde   = st_reg.txIde;
  assign txData  = st_reg.txData;
  assign irq     = st_reg.irq;

  // helper: buffers below the chosen target
  logic [NB-1:0] lowBits;
  always_comb
  begin
    for (int i = 0; i < NB; i++)
      lowBits[i] = (4'(i) < storeIdx);
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_disable_write;
    wrCtrl && !rxCapable(pwdata[3:0]);
  endsequence

  a_tag_clear_write: assert property (s_disable_write |=> !st_reg.tag[$past(selBuf)])
    else $error("tag survived a disabling state write");

  a_disabled_no_store: assert property (storeEn |->
      st_reg.bufState[storeIdx] != crtt_pkg::ST_RX_DISABLED ##1
      st_reg.bufState[$past(storeIdx)] != crtt_pkg::ST_RX_DISABLED)
    else $error("frame stored into a disabled buffer");

  a_rearm_not_copied: assert property ((hidValid && hidOwn && st_reg.lastValid &&
      hidId == st_reg.lastId && hidIde == st_reg.lastIde && !wrCtrl) |=>
      st_reg.tag == $past(st_reg.tag))
    else $error("tags changed on a scan of an unchanged identifier");

  a_single_send_req: assert property ((txPend != '0 && !st_reg.txBusy && !ownDone) |=>
      txReq && st_reg.bufState[st_reg.txBuf] == crtt_pkg::ST_TX_SINGLE)
    else $error("single-send buffer not requested");

  a_basic_path_use: assert property ((st_reg.basicEn && hidValid && !match[crtt_pkg::BASIC_BUF])
      |-> ((hidId ^ st_reg.bufId[crtt_pkg::BASIC_BUF]) &
           ~crtt_pkg::maskOf(st_reg.basicMask)) != '0 ||
          hidIde != st_reg.bufIde[crtt_pkg::BASIC_BUF])
    else $error("basic path refused a frame its masks accept");

  a_tx_stamp_cap: assert property (ownDone |=>
      st_reg.bufStamp[$past(st_reg.txBuf)] == $past(st_reg.ackStamp) && !txReq)
    else $error("sender stamp not taken from the ack slot");

  a_rx_stamp_cap: assert property (ackSlot ##1 !ackSlot ##1 (storeEn && !ackSlot) |=>
      st_reg.bufStamp[$past(storeIdx)] == $past(stampNow, 3))
    else $error("receiver stamp not taken from the ack slot");

  a_lowest_target: assert property (storeEn |-> (elig & lowBits) == '0 && elig[storeIdx])
    else $error("frame not stored into the lowest tagged buffer");

  a_new_id_rescan: assert property ((hidValid && (hidId != st_reg.lastId)) |=>
      st_reg.lastId == $past(hidId) && st_reg.lastValid)
    else $error("scan identifier not recorded");

  a_apb_one_wait: assert property ((psel && !penable) |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");

  a_irq_level: assert property (irq == ((st_reg.irqStatus & st_reg.irqMask) != '0))
    else $error("interrupt output disagrees with status and mask");

endmodule
`default_nettype wire

// ===== test/crtt_can_node.sv
`timescale 1ns/1ps
`default_nettype none
module crtt_can_node
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        txReq,
  input  wire logic [28:0] txId,
  input  wire logic        txIde,
  input  wire logic [31:0] txData,
  output logic             hidValid,
  output logic      [28:0] hidId,
  output logic             hidIde,
  output logic      [31:0] hidData,
  output logic             hidOwn,
  output logic             ackSlot,
  output logic             frameOk
);
  logic busy;

  // idle bus state at time zero
  initial
  begin
    busy     = 1'b0;
    hidValid = 1'b0;
    ackSlot  = 1'b0;
    frameOk  = 1'b0;
    hidId    = '0;
    hidIde   = 1'b0;
    hidData  = '0;
    hidOwn   = 1'b0;
  end

  // one frame: scan, ack slot, good end; lines scrambled once released
  task automatic frame(input logic [28:0] id, input logic ide, input logic [31:0] d,
                       input logic own);
    busy = 1'b1;
    @(posedge clk);
    hidValid <= 1'b1;
    hidId    <= id;
    hidIde   <= ide;
    hidOwn   <= own;
    @(posedge clk);
    hidValid <= 1'b0;
    repeat (3) @(posedge clk);
    ackSlot  <= 1'b1;
    @(posedge clk);
    ackSlot  <= 1'b0;
    @(posedge clk);
    frameOk  <= 1'b1;
    hidData  <= d;
    @(posedge clk);
    frameOk  <= 1'b0;
    hidId    <= ~id;
    hidIde   <= ~ide;
    hidData  <= ~d;
    hidOwn   <= ~own;
    busy = 1'b0;
  endtask

  // frame from another node, sent once the bus is free
  task automatic send(input logic [28:0] id, input logic ide, input logic [31:0] d);
    while (busy)
      @(negedge clk);
    frame(id, ide, d, 1'b0);
  endtask

  // own transmission is looped back through the hidden buffer
  always @(negedge clk)
    if (!rst && txReq === 1'b1 && !busy)
      frame(txId, txIde, txData, 1'b1);
endmodule
`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [31:0] data; logic [31:0] mask; logic err;} crtt_note_t;
  localparam logic [28:0] IDX = 29'h1555_5551;
  logic             clk, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic             hidValid, hidIde, hidOwn, ackSlot, frameOk, txReq, txIde;
  logic      [11:0] paddr;
  logic      [31:0] pwdata, prdata, rdv, hidData, txData, d, s;
  logic      [28:0] hidId, txId;
  int               err_count, tests_run, seed;
  crtt_note_t       q[$];
  crtt_note_t       n;

  crtt_can_buffers DUT (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hidValid(hidValid), .hidId(hidId), .hidIde(hidIde), .hidData(hidData), .hidOwn(hidOwn),
    .ackSlot(ackSlot), .frameOk(frameOk), .txReq(txReq), .txId(txId), .txIde(txIde),
    .txData(txData), .irq(irq));
  crtt_can_node node (.clk(clk), .rst(rst), .txReq(txReq), .txId(txId), .txIde(txIde),
    .txData(txData), .hidValid(hidValid), .hidId(hidId), .hidIde(hidIde), .hidData(hidData),
    .hidOwn(hidOwn), .ackSlot(ackSlot), .frameOk(frameOk));

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // apb master: setup, access held until pready seen high at an edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && k < 20)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 20)
      cmp("pready", 32'h1, 32'h0);
    rdv = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    apb(a, 1'b1, wd);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic er = 1'b0);
    q.push_back('{e, m, er});
    apb(a, 1'b0, 32'h0);
  endtask

  function automatic logic [11:0] ba(input int b, input logic [1:0] w);
    ba = {crtt_pkg::BUF_REGION, 4'(b), w, 2'b00};
  endfunction

  task automatic chk_irq(input logic e);
    @(negedge clk);
    cmp("irq", {31'h0, e}, {31'h0, irq});
  endtask

  task automatic fgn(input logic [28:0] id, input logic ide, input logic [31:0] dd);
    node.send(id, ide, dd);
    repeat (2) @(posedge clk);
  endtask

  // launch buffer 0 once and wait for its own frame to finish
  task automatic own_tx(input logic [31:0] ed);
    int k;
    k = 0;
    wr(ba(0, crtt_pkg::WORD_CONTROL), {28'h0, crtt_pkg::ST_TX_SINGLE});
    while (txReq !== 1'b1 && k < 20)
    begin
      @(negedge clk);
      k++;
    end
    cmp("txReq", 32'h1, {31'h0, txReq});
    cmp("txId", {3'h0, IDX}, {3'h0, txId});
    cmp("txIde", 32'h1, {31'h0, txIde});
    cmp("txData", ed, txData);
    while (txReq !== 1'b0 && k < 200)
    begin
      @(negedge clk);
      k++;
    end
    cmp("txDone", 32'h0, {31'h0, txReq});
    repeat (2) @(posedge clk);
  endtask

  // read notes taken off in order as answers appear
  always @(negedge clk)
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0)
    begin
      if (q.size() == 0)
        cmp("note", 32'h1, 32'h0);
      else
      begin
        n = q.pop_front();
        cmp("prdata", n.data & n.mask, prdata & n.mask);
        cmp("pslverr", {31'h0, n.err}, {31'h0, pslverr});
      end
    end

  initial
  begin
    #100000;
    err_count++;
    wrap_up();
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    err_count = 0;
    tests_run = 0;
    seed = 32'h6eda;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(crtt_pkg::OFF_CONFIG, 32'h0, 32'hffff_ffff);
    rd(ba(0, crtt_pkg::WORD_CONTROL), {28'h0, crtt_pkg::RST_STATE}, 32'hf);
    rd(12'hffc, 32'h0, 32'h0, 1'b1);
    chk_irq(1'b0);
    $display("test reset done");
    // erratum: rearm without disable, own frame lands in buffer 1
    for (int b = 0; b < 3; b++)
    begin
      wr(ba(b, crtt_pkg::WORD_IDENT), {3'b100, IDX});
      wr(ba(b, crtt_pkg::WORD_CONTROL), (b == 0) ? 32'h8 : 32'h2);
    end
    wr(crtt_pkg::OFF_IRQ_MASK, 32'h2);
    d = $random(seed);
    wr(ba(0, crtt_pkg::WORD_DATA), ~d);
    fgn(IDX, 1'b1, d);
    rd(ba(1, crtt_pkg::WORD_CONTROL), {28'h0, crtt_pkg::ST_RX_FULL}, 32'hf);
    rd(ba(1, crtt_pkg::WORD_DATA), d, 32'hffff_ffff);
    chk_irq(1'b1);
    wr(ba(1, crtt_pkg::WORD_CONTROL), {28'h0, crtt_pkg::ST_RX_ARMED});
    own_tx(~d);
    rd(ba(1, crtt_pkg::WORD_DATA), ~d, 32'hffff_ffff);
    rd(ba(0, crtt_pkg::WORD_CONTROL), {28'h0, crtt_pkg::ST_TX_IDLE}, 32'hf);
    rd(ba(0, crtt_pkg::WORD_STAMP), 32'h0, 32'h0);
    s = rdv;
    rd(ba(1, crtt_pkg::WORD_STAMP), s, 32'hffff);
    rd(ba(1, crtt_pkg::WORD_CONTROL), {28'h0, crtt_pkg::ST_RX_FULL}, 32'hf);
    rd(ba(2, crtt_pkg::WORD_CONTROL), {28'h0, crtt_pkg::ST_RX_ARMED}, 32'hf);
    $display("test self reception done");
    // workaround: disable then rearm every matching buffer before sending
    wr(ba(1, crtt_pkg::WORD_CONTROL), {28'h0, crtt_pkg::ST_RX_ARMED});
    fgn(IDX, 1'b1, $random(seed));
    for (int b = 1; b < 3; b++)
    begin
      wr(ba(b, crtt_pkg::WORD_CONTROL), {28'h0, crtt_pkg::ST_RX_DISABLED});
      wr(ba(b, crtt_pkg::WORD_CONTROL), {28'h0, crtt_pkg::ST_RX_ARMED});
    end
    rd(crtt_pkg::OFF_TAGS, 32'h0, 32'h7);
    own_tx(~d);
    rd(ba(1, crtt_pkg::WORD_CONTROL), {28'h0, crtt_pkg::ST_RX_ARMED}, 32'hf);
    rd(ba(2, crtt_pkg::WORD_CONTROL), {28'h0, crtt_pkg::ST_RX_ARMED}, 32'hf);
    $display("test tag clearing done");
    // disabled buffer loses the frame, next tagged buffer takes it
    wr(ba(1, crtt_pkg::WORD_CONTROL), {28'h0, crtt_pkg::ST_RX_DISABLED});
    fgn(29'h0000_0123, 1'b1, 32'h0);
    fgn(IDX, 1'b1, $random(seed));
    rd(ba(1, crtt_pkg::WORD_CONTROL), {28'h0, crtt_pkg::ST_RX_DISABLED}, 32'hf);
    rd(ba(2, crtt_pkg::WORD_CONTROL), {28'h0, crtt_pkg::ST_RX_FULL}, 32'hf);
    $display("test disabled buffer done");
    // basic path on buffer 14 takes any standard frame; its irq stays masked
    wr(crtt_pkg::OFF_IRQ_STATUS, 32'hffff_ffff);
    chk_irq(1'b0);
    wr(crtt_pkg::OFF_CONFIG, 32'h1 << crtt_pkg::CFG_BASIC_BIT);
    wr(crtt_pkg::OFF_BASIC_MASK, 32'hffff_ffff);
    wr(ba(14, crtt_pkg::WORD_CONTROL), {28'h0, crtt_pkg::ST_RX_ARMED});
    d = $random(seed);
    fgn(29'($random(seed)), 1'b0, d);
    rd(ba(14, crtt_pkg::WORD_CONTROL), {28'h0, crtt_pkg::ST_RX_FULL}, 32'hf);
    rd(ba(14, crtt_pkg::WORD_DATA), d, 32'hffff_ffff);
    rd(crtt_pkg::OFF_IRQ_STATUS, 32'h4000, 32'h4000);
    chk_irq(1'b0);
    wr(crtt_pkg::OFF_IRQ_STATUS, 32'hffff_ffff);
    rd(crtt_pkg::OFF_IRQ_STATUS, 32'h0, 32'hffff_ffff);
    $display("test basic path done");
    wrap_up();
  end
endmodule
`default_nettype wire
